/* File: gpio_pwm_pkg.sv */
package gpio_pwm_pkg;

    // ------------------------------------------------------------
    // Register indices, byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_PORT_A_LATCH = 6'h12;
    localparam logic [5:0] IDX_PORT_A_DIRECTION = 6'h13;
    localparam logic [5:0] IDX_PORT_B_LATCH = 6'h14;
    localparam logic [5:0] IDX_PORT_B_DIRECTION = 6'h15;
    localparam logic [5:0] IDX_PORT_C_LATCH = 6'h16;
    localparam logic [5:0] IDX_PORT_C_DIRECTION = 6'h17;
    localparam logic [5:0] IDX_PORT_D_LATCH = 6'h18;
    localparam logic [5:0] IDX_PORT_D_DIRECTION = 6'h19;
    localparam logic [5:0] IDX_PWM_DUTY = 6'h1A;
    localparam logic [5:0] IDX_PORTB_CONFIG = 6'h1B;
    localparam logic [5:0] IDX_BIT_OP = 6'h1C;

    localparam int NUM_PORTS = 4;
    localparam logic [5:0] IDX_LATCH [NUM_PORTS] = '{IDX_PORT_A_LATCH,
        IDX_PORT_B_LATCH, IDX_PORT_C_LATCH, IDX_PORT_D_LATCH};
    localparam logic [5:0] IDX_DIR [NUM_PORTS] = '{IDX_PORT_A_DIRECTION,
        IDX_PORT_B_DIRECTION, IDX_PORT_C_DIRECTION, IDX_PORT_D_DIRECTION};
    localparam logic [7:0] IMPL_MASK [NUM_PORTS] = '{8'hFF, 8'hFF, 8'h03,
        8'h01};

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'hFF;
    localparam logic [7:0] PWM_DUTY_RESET = 8'h00;
    localparam logic [2:0] PORTB_CONFIG_RESET = 3'h0;
    localparam logic [2:0] PORTB_CONFIG_ALL = 3'h7;

    // ------------------------------------------------------------
    // Bit operation register fields
    // ------------------------------------------------------------
    localparam int BITOP_BIT_LSB = 0;
    localparam int BITOP_PORT_LSB = 3;
    localparam int BITOP_OP_LSB = 5;
    localparam logic [1:0] OP_SET = 2'h0;
    localparam logic [1:0] OP_CLEAR = 2'h1;
    localparam logic [1:0] OP_COMPLEMENT = 2'h2;
    localparam logic [1:0] OP_NONE = 2'h3;

    // ------------------------------------------------------------
    // Bus answers and pin carriers
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int TONE_LINE = 3;

    typedef struct packed {
        logic [7:0] a;
        logic [7:0] b;
        logic [1:0] c;
        logic d;
    } pad_bus_s;

endpackage

/* File: io_ports_with_pwm_output.sv */
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
module io_ports_with_pwm_output
    import gpio_pwm_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter logic [3:0] PULL_OPT = 4'hF,
    parameter logic TONE_OPT = 1'b1,
    parameter logic PWM_OPT = 1'b1,
    parameter logic PWM_MODE_7P1 = 1'b0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire pad_bus_s pad_in,
    output pad_bus_s pad_out,
    output pad_bus_s pad_oe,
    output pad_bus_s pull_en,
    input wire logic timer_overflow,
    output logic ext_interrupt_n,
    output logic timer_clock_input,
    output logic wake_req,
    output logic adc_power_on,
    output logic [7:0] analog_mask
);

    if (ADDR_W < 8) begin : g_bad_addr
        $error("ADDR_W too small for the register map");
    end

    // ------------------------------------------------------------
    // Pad synchronisers
    // ------------------------------------------------------------
    pad_bus_s pad_meta_q;
    pad_bus_s pad_sync_q;
    logic [7:0] pa_prev_q;
    logic [7:0] pin_v [NUM_PORTS];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // Pulled-high idle level, so no false wake after reset
            pad_meta_q <= '1;
            pad_sync_q <= '1;
        end else begin
            pad_meta_q <= pad_in;
            pad_sync_q <= pad_meta_q;
        end
    end

    // Pads are read live, no input latch
    assign pin_v[0] = pad_sync_q.a;
    assign pin_v[1] = pad_sync_q.b;
    assign pin_v[2] = {6'h00, pad_sync_q.c};
    assign pin_v[3] = {7'h00, pad_sync_q.d};

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [7:0] latch_q [NUM_PORTS];
    logic [7:0] dir_q [NUM_PORTS];
    logic [7:0] pwm_duty_q;
    logic [2:0] portb_config_q;
    logic [7:0] port_val [NUM_PORTS];
    logic [7:0] analog_v;

    // ------------------------------------------------------------
    // Analog takeover of port B
    // ------------------------------------------------------------
    always_comb begin
        if (portb_config_q == PORTB_CONFIG_ALL) begin
            analog_v = 8'hFF;
        end else begin
            analog_v = 8'((9'h001 << portb_config_q) - 9'h001);
        end
    end

    // Mixed read value: pad for inputs, latch for outputs
    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            port_val[p] = ((dir_q[p] & pin_v[p]) | (~dir_q[p] & latch_q[p]))
                & IMPL_MASK[p];
        end
        port_val[1] = port_val[1] & ~analog_v;
    end

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    logic aw_hold_q;
    logic w_hold_q;
    logic [5:0] aw_idx_q;
    logic [7:0] w_data_q;
    logic w_strb0_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic do_write;
    logic wr_mapped;

    assign awready = !aw_hold_q && !bvalid_q;
    assign wready = !w_hold_q && !bvalid_q;
    assign do_write = aw_hold_q && w_hold_q && !bvalid_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign wr_mapped = (aw_idx_q >= IDX_PORT_A_LATCH)
        && (aw_idx_q <= IDX_BIT_OP);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            aw_idx_q <= '0;
        end else if (awvalid && awready) begin
            aw_hold_q <= 1'b1;
            aw_idx_q <= awaddr[7:2];
        end else if (do_write) begin
            aw_hold_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold_q <= 1'b0;
            w_data_q <= '0;
            w_strb0_q <= 1'b0;
        end else if (wvalid && wready) begin
            w_hold_q <= 1'b1;
            w_data_q <= wdata[7:0];
            w_strb0_q <= wstrb[0];
        end else if (do_write) begin
            w_hold_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Latch, direction and control writes
    // ------------------------------------------------------------
    logic [1:0] op_code;
    logic [1:0] op_port;
    logic [2:0] op_bit;
    logic [7:0] op_result;
    logic [7:0] lat_wd [NUM_PORTS];
    logic [NUM_PORTS-1:0] lat_we;

    assign op_code = w_data_q[BITOP_OP_LSB +: 2];
    assign op_port = w_data_q[BITOP_PORT_LSB +: 2];
    assign op_bit = w_data_q[BITOP_BIT_LSB +: 3];

    // Modify works on the whole port value as read
    always_comb begin
        case (op_code)
            OP_SET: op_result = port_val[op_port] | (8'h01 << op_bit);
            OP_CLEAR: op_result = port_val[op_port] & ~(8'h01 << op_bit);
            OP_COMPLEMENT: op_result = ~port_val[op_port];
            default: op_result = port_val[op_port];
        endcase
    end

    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            lat_we[p] = 1'b0;
            lat_wd[p] = latch_q[p];
            if (do_write && w_strb0_q) begin
                if (aw_idx_q == IDX_LATCH[p]) begin
                    lat_we[p] = 1'b1;
                    lat_wd[p] = w_data_q & IMPL_MASK[p];
                end else if (aw_idx_q == IDX_BIT_OP && op_code != OP_NONE
                    && op_port == 2'(p)) begin
                    lat_we[p] = 1'b1;
                    lat_wd[p] = op_result & IMPL_MASK[p];
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                latch_q[p] <= LATCH_RESET;
            end
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (lat_we[p]) begin
                    latch_q[p] <= lat_wd[p];
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                dir_q[p] <= DIR_RESET & IMPL_MASK[p];
            end
        end else if (do_write && w_strb0_q) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (aw_idx_q == IDX_DIR[p]) begin
                    dir_q[p] <= w_data_q & IMPL_MASK[p];
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwm_duty_q <= PWM_DUTY_RESET;
            portb_config_q <= PORTB_CONFIG_RESET;
        end else if (do_write && w_strb0_q) begin
            if (aw_idx_q == IDX_PWM_DUTY) begin
                pwm_duty_q <= w_data_q;
            end
            if (aw_idx_q == IDX_PORTB_CONFIG) begin
                portb_config_q <= w_data_q[2:0];
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    logic [5:0] ar_idx;
    logic [7:0] rd_mux;
    logic rd_hit;
    logic rvalid_q;
    logic [7:0] rdata_q;
    logic [1:0] rresp_q;

    assign ar_idx = araddr[7:2];
    assign arready = !rvalid_q;
    assign rvalid = rvalid_q;
    assign rdata = {24'h000000, rdata_q};
    assign rresp = rresp_q;

    always_comb begin
        rd_mux = 8'h00;
        rd_hit = 1'b1;
        case (ar_idx)
            IDX_PORT_A_LATCH: rd_mux = port_val[0];
            IDX_PORT_B_LATCH: rd_mux = port_val[1];
            IDX_PORT_C_LATCH: rd_mux = port_val[2];
            IDX_PORT_D_LATCH: rd_mux = port_val[3];
            IDX_PORT_A_DIRECTION: rd_mux = dir_q[0];
            IDX_PORT_B_DIRECTION: rd_mux = dir_q[1];
            IDX_PORT_C_DIRECTION: rd_mux = dir_q[2];
            IDX_PORT_D_DIRECTION: rd_mux = dir_q[3];
            IDX_PWM_DUTY: rd_mux = pwm_duty_q;
            IDX_PORTB_CONFIG: rd_mux = {5'h00, portb_config_q};
            IDX_BIT_OP: rd_mux = 8'h00;
            default: rd_hit = 1'b0;
        endcase
    end

    // Pad value is captured at the edge the read is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Tone divider and PWM generator
    // ------------------------------------------------------------
    logic tone_q;
    logic [7:0] pwm_cnt_q;
    logic [7:0] pwm_pos;
    logic [7:0] pwm_base;
    logic [1:0] pwm_idx;
    logic [1:0] pwm_extra;
    logic [7:0] pwm_high_cnt;
    logic pwm_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tone_q <= 1'b0;
        end else if (timer_overflow) begin
            tone_q <= !tone_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwm_cnt_q <= '0;
        end else begin
            pwm_cnt_q <= pwm_cnt_q + 8'h01;
        end
    end

    always_comb begin
        if (PWM_MODE_7P1) begin
            pwm_idx = {1'b0, pwm_cnt_q[7]};
            pwm_pos = {1'b0, pwm_cnt_q[6:0]};
            pwm_base = {1'b0, pwm_duty_q[7:1]};
            pwm_extra = {1'b0, pwm_duty_q[0]};
        end else begin
            pwm_idx = pwm_cnt_q[7:6];
            pwm_pos = {2'b00, pwm_cnt_q[5:0]};
            pwm_base = {2'b00, pwm_duty_q[7:2]};
            pwm_extra = pwm_duty_q[1:0];
        end
        pwm_high_cnt = pwm_base + ((pwm_idx < pwm_extra) ? 8'h01 : 8'h00);
    end

    // Duty is read live; a write lands mid-cycle, not at the next cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwm_q <= 1'b0;
        end else begin
            pwm_q <= pwm_pos < pwm_high_cnt;
        end
    end

    // ------------------------------------------------------------
    // Pad drive, enables and shared functions
    // ------------------------------------------------------------
    logic [7:0] out_v [NUM_PORTS];
    logic [7:0] oe_v [NUM_PORTS];
    logic [7:0] pu_v [NUM_PORTS];

    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            out_v[p] = latch_q[p] & IMPL_MASK[p];
            oe_v[p] = ~dir_q[p] & IMPL_MASK[p];
            pu_v[p] = PULL_OPT[p] ? (dir_q[p] & IMPL_MASK[p]) : 8'h00;
        end
        if (TONE_OPT) begin
            out_v[0][TONE_LINE] = latch_q[0][TONE_LINE] & tone_q;
        end
        if (PWM_OPT) begin
            out_v[3][0] = latch_q[3][0] & pwm_q;
        end
        out_v[1] = out_v[1] & ~analog_v;
        oe_v[1] = oe_v[1] & ~analog_v;
        pu_v[1] = pu_v[1] & ~analog_v;
    end

    // Registered so the pins never glitch on mux changes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pad_out <= '0;
            pad_oe <= '0;
            pull_en <= '0;
        end else begin
            pad_out <= {out_v[0], out_v[1], out_v[2][1:0], out_v[3][0]};
            pad_oe <= {oe_v[0], oe_v[1], oe_v[2][1:0], oe_v[3][0]};
            pull_en <= {pu_v[0], pu_v[1], pu_v[2][1:0], pu_v[3][0]};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pa_prev_q <= '1;
            wake_req <= 1'b0;
            ext_interrupt_n <= 1'b1;
            timer_clock_input <= 1'b0;
            adc_power_on <= 1'b0;
            analog_mask <= '0;
        end else begin
            pa_prev_q <= pad_sync_q.a;
            wake_req <= |((pad_sync_q.a ^ pa_prev_q) & dir_q[0]);
            ext_interrupt_n <= pad_sync_q.a[5];
            timer_clock_input <= pad_sync_q.a[4];
            adc_power_on <= portb_config_q != PORTB_CONFIG_RESET;
            analog_mask <= analog_v;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence write_ready_s;
        aw_hold_q && w_hold_q && !bvalid_q;
    endsequence

    sequence resp_out_s;
        bvalid_q ##1 (bvalid_q || $past(bready));
    endsequence

    chk_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
        write_ready_s |=> resp_out_s)
        else $error("write response missing");

    chk_reset_inputs: assert property (@(posedge aclk)
        $rose(aresetn) |-> (pad_oe == '0) ##1 (pad_oe == '0))
        else $error("line driven right after reset");

    chk_tone_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
        timer_overflow |=> tone_q != $past(tone_q))
        else $error("tone did not toggle on overflow");

    chk_pwm_period: assert property (@(posedge aclk) disable iff (!aresetn)
        (pwm_cnt_q == 8'hFF) |=> (pwm_cnt_q == 8'h00))
        else $error("pwm cycle not 256 clocks");

    chk_pwm_rise: assert property (@(posedge aclk) disable iff (!aresetn)
        (pwm_pos == 8'h00 && pwm_high_cnt != 8'h00) |=> pwm_q)
        else $error("pwm did not rise at cycle start");

    chk_pwm_fall: assert property (@(posedge aclk) disable iff (!aresetn)
        (pwm_pos >= pwm_high_cnt) |=> !pwm_q)
        else $error("pwm high too long");

    chk_pd0_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        !latch_q[3][0] |=> !pad_out.d)
        else $error("line D0 not forced low");

    chk_pa3_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        !latch_q[0][TONE_LINE] |=> !pad_out.a[TONE_LINE])
        else $error("line A3 not forced low");

    chk_latch_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        !lat_we[0] |=> $stable(latch_q[0]))
        else $error("latch changed without write");

    chk_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        (arvalid && arready && ar_idx == IDX_PORT_C_LATCH)
        |=> rdata[7:2] == 6'h00)
        else $error("unimplemented bits not zero");

    chk_read_mix: assert property (@(posedge aclk) disable iff (!aresetn)
        (arvalid && arready && ar_idx == IDX_PORT_A_LATCH)
        |=> rdata[7:0] == (($past(dir_q[0]) & $past(pad_sync_q.a))
        | (~$past(dir_q[0]) & $past(latch_q[0]))))
        else $error("port read mix wrong");

    chk_analog_off: assert property (@(posedge aclk) disable iff (!aresetn)
        (portb_config_q == PORTB_CONFIG_ALL)
        |=> (pad_oe.b == 8'h00 && pull_en.b == 8'h00))
        else $error("analog line still digital");

    chk_wake_change: assert property (@(posedge aclk) disable iff (!aresetn)
        (((pad_sync_q.a ^ pa_prev_q) & dir_q[0]) != 8'h00) |=> wake_req)
        else $error("no wake on port A change");

endmodule

/* File: pin_board.sv */
`timescale 1ns/1ps
module pin_board
    import gpio_pwm_pkg::*;
(
    input wire logic aclk,
    input wire pad_bus_s pad_out,
    input wire pad_bus_s pad_oe,
    input wire pad_bus_s pull_en,
    input wire pad_bus_s ext_val,
    input wire pad_bus_s ext_en,
    output pad_bus_s pad_in
);
    // ----
    // Undriven, unpulled lines wobble, never hold
    // ----
    logic wobble_q = 1'b0;

    always_ff @(posedge aclk) begin
        wobble_q <= !wobble_q;
    end

    // Device wins while enabled, then board, then pull
    always_comb begin
        pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
            | (~pad_oe & ~ext_en & (pull_en | {19{wobble_q}}));
    end
endmodule

/* File: tb.sv */
`timescale 1ns/1ps
module tb
    import gpio_pwm_pkg::*;
();
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, v, e;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, timer_overflow = 1'b0;
    logic [31:0] wdata = 32'h0, rdata, dat, x;
    logic awready, wready, bvalid, arready, rvalid, t;
    logic [1:0] bresp, rresp, rsp;
    pad_bus_s pad_in, pad_out, pad_oe, pull_en, ext_val, ext_en;
    logic ext_interrupt_n, timer_clock_input, wake_req, adc_power_on;
    logic [7:0] analog_mask;
    logic [7:0] vs [4];
    pad_bus_s pad_out_7p1;
    int fail_count = 0, check_count = 0, n, n7, b;

    always #2.5 aclk = !aclk;

    io_ports_with_pwm_output dut (.aclk, .aresetn, .awaddr,
        .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'hF),
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .pad_in, .pad_out, .pad_oe, .pull_en, .timer_overflow,
        .ext_interrupt_n, .timer_clock_input, .wake_req, .adc_power_on,
        .analog_mask);

    pin_board board (.aclk, .pad_out, .pad_oe, .pull_en, .ext_val,
        .ext_en, .pad_in);

    // Seven-one build sees the same bus, only its PWM line is watched
    io_ports_with_pwm_output #(.PWM_MODE_7P1(1'b1)) dut_7p1 (.aclk,
        .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready(),
        .wdata, .wstrb(4'hF), .wvalid, .wready(), .bresp(), .bvalid(),
        .bready, .araddr, .arprot(3'h0), .arvalid, .arready(),
        .rdata(), .rresp(), .rvalid(), .rready, .pad_in,
        .pad_out(pad_out_7p1), .pad_oe(), .pull_en(),
        .timer_overflow, .ext_interrupt_n(), .timer_clock_input(),
        .wake_req(), .adc_power_on(), .analog_mask());

    // ----
    // Bus and compare tasks
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [5:0] i, input logic [7:0] d);
        @(posedge aclk);
        awaddr <= {i, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= '1;
        wvalid <= '1;
        bready <= '1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= '0;
            if (wready) wvalid <= '0;
        end while (!bvalid);
        rsp = bresp;
        bready <= '0;
    endtask

    task automatic rd(input logic [5:0] i);
        @(posedge aclk);
        araddr <= {i, 2'h0};
        arvalid <= '1;
        rready <= '1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= '0;
        end while (!rvalid);
        dat = rdata;
        rsp = rresp;
        rready <= '0;
    endtask

    function automatic logic [7:0] pv(pad_bus_s s, int p);
        case (p)
            0: return s.a;
            1: return s.b;
            2: return {6'h00, s.c};
            default: return {7'h00, s.d};
        endcase
    endfunction

    // High clocks over one full cycle, six-two split
    function automatic int pwm_ones(logic [7:0] d);
        int k;
        k = 0;
        for (int i = 0; i < 4; i++) k += d[7:2] + (i < d[1:0]);
        return k;
    endfunction

    // High clocks over one full cycle, seven-one split
    function automatic int pwm_ones_7p1(logic [7:0] d);
        int k;
        k = 0;
        for (int i = 0; i < 2; i++) k += d[7:1] + (i < d[0]);
        return k;
    endfunction

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        tally_and_finish();
    end

    // ----
    // Tests
    // ----
    initial begin
        void'($urandom(32'h90015FBE));
        ext_val = '0;
        ext_en = '0;
        repeat (3) @(posedge aclk);
        aresetn <= '1;
        for (int p = 0; p < 4; p++) begin
            rd(IDX_DIR[p]);
            chk(dat, {24'h0, IMPL_MASK[p]});
        end
        chk(pad_oe, '0);
        chk(pull_en, 32'h7FFFF);
        $display("reset test done");
        for (int p = 0; p < 4; p++) begin
            vs[p] = 8'($urandom);
            wr(IDX_LATCH[p], vs[p]);
            chk(rsp, RESP_OKAY);
            wr(IDX_DIR[p], 8'h00);
            rd(IDX_LATCH[p]);
            chk(dat, {24'h0, vs[p] & IMPL_MASK[p]});
            rd(IDX_DIR[p]);
            chk(dat, '0);
        end
        repeat (3) @(posedge aclk);
        chk(pad_out.b, vs[1]);
        chk(pad_oe.b, 8'hFF);
        chk(pad_out.c, vs[2][1:0]);
        $display("output test done");
        x = $urandom;
        ext_val <= x[18:0];
        ext_en <= '1;
        for (int p = 0; p < 4; p++) wr(IDX_DIR[p], 8'hFF);
        repeat (4) @(posedge aclk);
        for (int p = 0; p < 4; p++) begin
            rd(IDX_LATCH[p]);
            chk(dat, {24'h0, pv(ext_val, p)});
        end
        chk(ext_interrupt_n, ext_val.a[5]);
        chk(timer_clock_input, ext_val.a[4]);
        ext_val.a <= ~x[7:0];
        n = 0;
        repeat (8) begin
            @(posedge aclk);
            n += wake_req;
        end
        chk(n > 0, 1);
        $display("input test done");
        wr(IDX_DIR[0], 8'h00);
        for (int op = 0; op < 3; op++) begin
            v = 8'($urandom);
            b = $urandom % 8;
            wr(IDX_LATCH[0], v);
            wr(IDX_BIT_OP, {1'b0, 2'(op), 2'h0, 3'(b)});
            rd(IDX_LATCH[0]);
            e = op == 0 ? v | (8'h01 << b) : op == 1 ? v & ~(8'h01 << b) : ~v;
            chk(dat, {24'h0, e});
        end
        $display("bit op test done");
        wr(IDX_LATCH[0], 8'h08);
        repeat (3) @(posedge aclk);
        t = pad_out.a[3];
        for (int k = 0; k < 2; k++) begin
            timer_overflow <= '1;
            @(posedge aclk);
            timer_overflow <= '0;
            repeat (4) @(posedge aclk);
            t = !t;
            chk(pad_out.a[3], t);
        end
        wr(IDX_LATCH[0], 8'h00);
        repeat (3) @(posedge aclk);
        chk(pad_out.a[3], '0);
        $display("tone test done");
        wr(IDX_DIR[3], 8'h00);
        wr(IDX_LATCH[3], 8'h01);
        for (int k = 0; k < 3; k++) begin
            v = k == 0 ? 8'hFF : k == 1 ? 8'h01 : 8'($urandom);
            wr(IDX_PWM_DUTY, v);
            repeat (260) @(posedge aclk);
            n = 0;
            n7 = 0;
            repeat (256) begin
                @(posedge aclk);
                n += pad_out.d;
                n7 += pad_out_7p1.d;
            end
            chk(n, pwm_ones(v));
            chk(n7, pwm_ones_7p1(v));
        end
        wr(IDX_LATCH[3], 8'h00);
        repeat (3) @(posedge aclk);
        chk(pad_out.d, '0);
        $display("pwm test done");
        for (int k = 0; k < 8; k++) begin
            wr(IDX_PORTB_CONFIG, 8'(k));
            repeat (3) @(posedge aclk);
            e = k == 7 ? 8'hFF : (8'h01 << k) - 8'h01;
            chk(analog_mask, e);
            chk(adc_power_on, k != 0);
            chk(pull_en.b, 8'(~e));
        end
        rd(6'h00);
        chk(rsp, RESP_SLVERR);
        chk(dat, '0);
        wr(6'h3F, 8'hFF);
        chk(rsp, RESP_SLVERR);
        $display("config test done");
        tally_and_finish();
    end
endmodule
